// ---- pkg/tcs_cfg.svh ----
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
// clock select encodings
`define TCS_SEL_INSTR 2'h0
`define TCS_SEL_SYS 2'h1
`define TCS_SEL_EXT 2'h2
// instruction clock is the system clock divided by four
`define TCS_INSTR_DIV_LAST 2'h3
`define TCS_DIV_ZERO 2'h0
`define TCS_COUNT_ZERO 16'h0000
`define TCS_COUNT_ONE 16'h0001
`define TCS_BYTE_ZERO 8'h00
`define TCS_PRE_ZERO 8'h00
`define TCS_PRE_ONE 8'h01
`define TCS_SYNC_ZERO 3'h0
`endif

// ---- pkg/tcs_pkg.sv ----
package tcs_pkg;
  // clock source decoded from select field and oscillator enable
  typedef enum logic [1:0] {
    SRC_INSTR = 2'b00,
    SRC_SYS = 2'b01,
    SRC_EXT = 2'b10,
    SRC_OSC = 2'b11
  } tcs_src_type;
endpackage : tcs_pkg

// ---- rtl/tcs_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module tcs_timer #(
  parameter int PRE_W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] clkSrcSel,
  input wire logic secOscEnable,
  input wire logic timerOn,
  input wire logic gateEnable,
  input wire logic gateOpen,
  input wire logic extSync,
  input wire logic [PRE_W-1:0] prescale,
  input wire logic instrTick,
  input wire logic extRise,
  input wire logic extFall,
  input wire logic extLevel,
  input wire logic oscRise,
  input wire logic writeHigh,
  input wire logic writeLow,
  input wire logic [7:0] writeData,
  output logic [15:0] count,
  output logic armed
);
  import tcs_pkg::*;
  // ==========================================================
  // source decode
  tcs_src_type src;
  wire logic extMode;
  wire logic runEn;
  wire logic srcTick;
  wire logic preDone;
  wire logic doInc;
  wire logic doWrite;
  wire logic [15:0] wrValue;
  logic [PRE_W-1:0] preCnt_ff;
  logic [15:0] count_ff;
  logic armed_ff;
  assign src = (clkSrcSel == `TCS_SEL_SYS) ? SRC_SYS :
               (clkSrcSel == `TCS_SEL_EXT) ? (secOscEnable ? SRC_OSC : SRC_EXT) : SRC_INSTR;
  assign extMode = (src == SRC_EXT);
  assign runEn = timerOn && (!gateEnable || gateOpen);
  // system source ticks every cycle: four counts per instruction cycle
  assign srcTick = (src == SRC_SYS) ? 1'b1 :
                   (src == SRC_INSTR) ? instrTick :
                   (src == SRC_OSC) ? oscRise :
                   (extRise && armed);
  assign preDone = (preCnt_ff == prescale) || (prescale == PRE_W'(`TCS_PRE_ZERO));
  assign doInc = runEn && srcTick && preDone;
  assign doWrite = writeHigh || writeLow;
  assign wrValue = writeHigh ? {writeData, count[7:0]} : {count[15:8], writeData};
  assign count = count_ff;
  assign armed = armed_ff;
  // ==========================================================
  // prescaler counts source ticks between increments
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      preCnt_ff <= '0;
    end else if (doWrite || !runEn) begin
      preCnt_ff <= '0;
    end else if (srcTick) begin
      preCnt_ff <= preDone ? '0 : preCnt_ff + PRE_W'(`TCS_PRE_ONE);
    end
  end
  // counter: write loads at once, holds while off
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_ff <= `TCS_COUNT_ZERO;
    end else if (doWrite) begin
      count_ff <= wrValue;
    end else if (doInc) begin
      count_ff <= count_ff + `TCS_COUNT_ONE;
    end
  end
  // falling edge must be seen before first counted rising edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      armed_ff <= 1'b0;
    end else begin
      if (doWrite || !timerOn || !extMode) begin
        armed_ff <= 1'b0;
      end else if (extFall) begin
        armed_ff <= 1'b1;
      end
    end
  end
  // path choice and held pin level are handled in the top; kept for completeness
  wire logic unusedSync;
  assign unusedSync = extSync || extLevel;
endmodule : tcs_timer
`default_nettype wire

// ---- rtl/tcs_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
// Behaviour
// - 16-bit counter, byte writes load immediately
// - counts only when on, gate allows
// - select field picks counting source
// - one shared secondary oscillator, any enable
// - internal source advances via prescaler
// - system clock: four counts per instruction
// - external pin counts on rising edges
// - external input synchronised on both extSync paths, same filter
// - falling edge required before first external pin count
// - secondary oscillator output is counted
module tcs_top #(
  parameter int NT = 3,
  parameter int PRE_W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2*NT-1:0] clkSrcSel,
  input wire logic [NT-1:0] secOscEnable,
  input wire logic [NT-1:0] timerOn,
  input wire logic [NT-1:0] gateEnable,
  input wire logic [NT-1:0] gateInputPin,
  input wire logic [NT-1:0] extSync,
  input wire logic [NT*PRE_W-1:0] prescale,
  input wire logic [NT-1:0] extCountClkPin,
  input wire logic secOscInPin,
  input wire logic [NT-1:0] writeHigh,
  input wire logic [NT-1:0] writeLow,
  input wire logic [7:0] writeData,
  output logic [NT*8-1:0] countHighByte,
  output logic [NT*8-1:0] countLowByte,
  output logic secOscRun,
  output logic secOscOutPin
);
  import tcs_pkg::*;
  // ==========================================================
  // pin filter helpers, shared by every filtered pin
  // shift a pin sample into its three-flop filter
  function automatic logic [2:0] tcs_shift(input logic [2:0] s, input logic pin);
    return {s[1:0], pin};
  endfunction : tcs_shift
  // a level counts once the second and third flops agree
  function automatic logic tcs_settled(input logic [2:0] s);
    return s[1] == s[2];
  endfunction : tcs_settled
  // settled high while the held level is still low
  function automatic logic tcs_rise_seen(input logic [2:0] s, input logic lvl);
    return tcs_settled(s) && s[2] && !lvl;
  endfunction : tcs_rise_seen
  // settled low while the held level is still high
  function automatic logic tcs_fall_seen(input logic [2:0] s, input logic lvl);
    return tcs_settled(s) && !s[2] && lvl;
  endfunction : tcs_fall_seen
  // ==========================================================
  // limitations
  // the asynchronous count path is filtered like the synchronous one,
  // so both paths see a pin edge about four clocks late
  // count pins must rest high and low for two clocks or more
  // the gate pin passes the same filter, so gating lags the pin too
  // all timers share one instruction divider, so their ticks align
  // the prescaler also divides the external and crystal sources
  // a write and an increment in the same cycle: the write wins
  // ==========================================================
  // instruction clock divider
  logic [1:0] div_ff;
  wire logic [1:0] nxt_div;
  wire logic instrTick;
  // one instruction tick in every four system clocks
  assign instrTick = (div_ff == `TCS_INSTR_DIV_LAST);
  assign nxt_div = div_ff + 2'h1;
  // divider runs from reset and never stops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_ff <= `TCS_DIV_ZERO;
    end else begin
      div_ff <= nxt_div;
    end
  end
  // ==========================================================
  // shared secondary oscillator, on if any timer enables it
  wire logic oscOn;
  assign oscOn = |secOscEnable;
  // crystal filter flops and held level
  logic [2:0] oscSync_ff;
  logic oscLvl_ff;
  wire logic oscRise;
  wire logic oscDrive;
  // a settled rising crystal edge, counted only while the oscillator runs
  assign oscRise = tcs_rise_seen(oscSync_ff, oscLvl_ff) && oscOn;
  // inverting amplifier drive, held low while the oscillator is off
  assign oscDrive = oscOn && !oscSync_ff[2];
  // crystal input filter and held level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      oscSync_ff <= `TCS_SYNC_ZERO;
      oscLvl_ff <= 1'b0;
    end else begin
      oscSync_ff <= tcs_shift(oscSync_ff, secOscInPin);
      if (tcs_settled(oscSync_ff)) begin
        oscLvl_ff <= oscSync_ff[2];
      end
    end
  end
  // oscillator status and drive pins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      secOscRun <= 1'b0;
      secOscOutPin <= 1'b0;
    end else begin
      secOscRun <= oscOn;
      secOscOutPin <= oscDrive;
    end
  end
  // ==========================================================
  // per-timer pin conditioning and counters
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tmr
      // filter flops and held levels
      logic [2:0] extS_ff;
      logic extL_ff;
      logic [2:0] gateS_ff;
      logic asyncPrev_ff;
      // edge, gate and field decode
      wire logic extAgree;
      wire logic syncRise;
      wire logic syncFall;
      wire logic asyncRise;
      wire logic asyncFall;
      wire logic selRise;
      wire logic selFall;
      wire logic gateOpen;
      wire logic [1:0] selField;
      wire logic [PRE_W-1:0] preField;
      wire logic [15:0] cnt;
      // ========================================================
      // count pin edges, synchronised path
      assign extAgree = tcs_settled(extS_ff);
      assign syncRise = tcs_rise_seen(extS_ff, extL_ff);
      assign syncFall = tcs_fall_seen(extS_ff, extL_ff);
      // asynchronous path shares the same three-flop filter and latency
      assign asyncRise = tcs_rise_seen(extS_ff, asyncPrev_ff);
      assign asyncFall = tcs_fall_seen(extS_ff, asyncPrev_ff);
      // path choice per timer
      assign selRise = extSync[gi] ? syncRise : asyncRise;
      assign selFall = extSync[gi] ? syncFall : asyncFall;
      // gate pin opens the count once settled high
      assign gateOpen = tcs_settled(gateS_ff) && gateS_ff[2];
      // this timer's fields of the shared control buses
      assign selField = clkSrcSel[2*gi +: 2];
      assign preField = prescale[PRE_W*gi +: PRE_W];
      // ========================================================
      // count pin filter and held levels
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          extS_ff <= `TCS_SYNC_ZERO;
          extL_ff <= 1'b0;
          asyncPrev_ff <= 1'b0;
        end else begin
          extS_ff <= tcs_shift(extS_ff, extCountClkPin[gi]);
          if (extAgree) begin
            extL_ff <= extS_ff[2];
            asyncPrev_ff <= extS_ff[2];
          end
        end
      end
      // gate pin filter
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          gateS_ff <= `TCS_SYNC_ZERO;
        end else begin
          gateS_ff <= tcs_shift(gateS_ff, gateInputPin[gi]);
        end
      end
      // ========================================================
      // one counter per slice, fed by the decoded sources
      tcs_timer #(.PRE_W(PRE_W)) u_tmr (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clkSrcSel(selField),
        .secOscEnable(secOscEnable[gi]),
        .timerOn(timerOn[gi]),
        .gateEnable(gateEnable[gi]),
        .gateOpen(gateOpen),
        .extSync(extSync[gi]),
        .prescale(preField),
        .instrTick(instrTick),
        .extRise(selRise),
        .extFall(selFall),
        .extLevel(extL_ff),
        .oscRise(oscRise),
        .writeHigh(writeHigh[gi]),
        .writeLow(writeLow[gi]),
        .writeData(writeData),
        .count(cnt),
        .armed()
      );
      // ========================================================
      // count bytes, registered per timer
      logic [7:0] hiByte_ff;
      logic [7:0] loByte_ff;
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          hiByte_ff <= `TCS_BYTE_ZERO;
          loByte_ff <= `TCS_BYTE_ZERO;
        end else begin
          hiByte_ff <= cnt[15:8];
          loByte_ff <= cnt[7:0];
        end
      end
      // outputs straight from flops
      assign countHighByte[8*gi +: 8] = hiByte_ff;
      assign countLowByte[8*gi +: 8] = loByte_ff;
    end
  endgenerate
endmodule : tcs_top
`default_nettype wire

// ---- tb/tcs_top_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
// =====
// port checks, timer 0 and shared oscillator
module tcs_top_checker #(
  parameter int NT = 3,
  parameter int PRE_W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2*NT-1:0] clkSrcSel,
  input wire logic [NT-1:0] secOscEnable,
  input wire logic [NT-1:0] timerOn,
  input wire logic [NT-1:0] gateEnable,
  input wire logic [NT-1:0] gateInputPin,
  input wire logic [NT*PRE_W-1:0] prescale,
  input wire logic [NT-1:0] writeHigh,
  input wire logic [NT-1:0] writeLow,
  input wire logic [7:0] writeData,
  input wire logic [NT*8-1:0] countHighByte,
  input wire logic [NT*8-1:0] countLowByte,
  input wire logic secOscRun
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // timer 0 view and quiet conditions
  wire logic [15:0] cnt = {countHighByte[7:0], countLowByte[7:0]};
  wire logic idle0 = !writeHigh[0] && !writeLow[0];
  wire logic free0 = timerOn[0] && !gateEnable[0] && idle0;
  wire logic pre0 = prescale[PRE_W-1:0] == PRE_W'(0);
  wire logic pre1 = prescale[PRE_W-1:0] == PRE_W'(1);
  sequence s_low_load;
    writeLow[0] && !writeHigh[0] && !timerOn[0] ##1 (idle0 && !timerOn[0])[*2];
  endsequence
  sequence s_held_off;
    (idle0 && !timerOn[0])[*3];
  endsequence
  a_low_load: assert property (s_low_load |-> countLowByte[7:0] == $past(writeData, 2))
    else $error("low byte write not loaded");
  a_off_hold: assert property (s_held_off |=> $stable(cnt))
    else $error("count moved while off");
  a_sys_rate: assert property ((free0 && pre0 && clkSrcSel[1:0] == 2'h1)[*3]
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("system clock rate wrong");
  a_instr_rate: assert property ((free0 && pre0 && clkSrcSel[1:0] == 2'h0)[*6]
    |=> cnt == $past(cnt, 4) + 16'h0001)
    else $error("instruction clock rate wrong");
  a_pre_rate: assert property ((free0 && pre1 && clkSrcSel[1:0] == 2'h1)[*4]
    |=> cnt == $past(cnt, 2) + 16'h0001)
    else $error("prescaled rate wrong");
  a_gate_shut: assert property ((timerOn[0] && gateEnable[0] && !gateInputPin[0] && idle0)[*6]
    |=> $stable(cnt))
    else $error("count moved with gate shut");
  a_osc_on: assert property (|secOscEnable |=> secOscRun)
    else $error("oscillator not running");
  a_osc_off: assert property (~|secOscEnable |=> !secOscRun)
    else $error("oscillator running unasked");
endmodule : tcs_top_checker
`default_nettype wire

// ---- tb/tcs_ext_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// =====
// far side: external count clock and crystal stand-in
module tcs_ext_src (
  input wire logic extRun,
  output logic extPin,
  output logic oscPin
);
  // crystal runs free, period scaled to 80 ns
  initial begin
    oscPin = 1'b0;
    forever #40 oscPin = !oscPin;
  end
  // count clock rests low, whole periods of 48 ns only
  initial begin
    extPin = 1'b0;
    forever begin
      wait (extRun);
      #24 extPin = 1'b1;
      #24 extPin = 1'b0;
    end
  end
endmodule : tcs_ext_src
`default_nettype wire

// ---- tb/tcs_top_test.sv ----
`timescale 1ns/1ns
`default_nettype none
// =====
// bench
module tcs_top_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic extRun = 1'b0;
  logic [5:0] clkSrcSel = 6'h00;
  logic [2:0] secOscEnable = 3'h0, timerOn = 3'h0, gateEnable = 3'h0, gateInputPin = 3'h0;
  logic [2:0] extSync = 3'h7, writeHigh = 3'h0, writeLow = 3'h0;
  logic [23:0] prescale = 24'h000000;
  logic [7:0] writeData = 8'h00;
  logic [15:0] c0;
  wire logic extPin, oscPin, secOscRun, secOscOutPin;
  wire logic [23:0] countHighByte, countLowByte;
  wire logic [15:0] cnt = {countHighByte[7:0], countLowByte[7:0]};
  int n_fail = 0;
  int samples_checked = 0;
  always #4 clk_sys = !clk_sys;
  tcs_top i_tcs_top (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clkSrcSel(clkSrcSel),
    .secOscEnable(secOscEnable),
    .timerOn(timerOn),
    .gateEnable(gateEnable),
    .gateInputPin(gateInputPin),
    .extSync(extSync),
    .prescale(prescale),
    .extCountClkPin({2'h0, extPin}),
    .secOscInPin(oscPin),
    .writeHigh(writeHigh),
    .writeLow(writeLow),
    .writeData(writeData),
    .countHighByte(countHighByte),
    .countLowByte(countLowByte),
    .secOscRun(secOscRun),
    .secOscOutPin(secOscOutPin)
  );
  tcs_ext_src i_tcs_ext_src (.extRun(extRun), .extPin(extPin), .oscPin(oscPin));
  // =====
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic load(input logic [15:0] v);
    writeHigh[0] = 1'b1;
    writeData = v[15:8];
    cyc(1);
    writeHigh[0] = 1'b0;
    writeLow[0] = 1'b1;
    writeData = v[7:0];
    cyc(1);
    writeLow[0] = 1'b0;
    cyc(3);
  endtask : load
  // advance over 8 cycles for one source and prescale
  task automatic rate(input logic [1:0] sel, input logic [7:0] pre, input logic [15:0] exp);
    clkSrcSel[1:0] = sel;
    prescale[7:0] = pre;
    timerOn[0] = 1'b1;
    cyc(4);
    c0 = cnt;
    cyc(8);
    check("rate", exp, cnt - c0);
  endtask : rate
  // =====
  // scenarios
  task automatic t_load;
    load(16'ha53c);
    check("load", 16'ha53c, cnt);
    cyc(6);
    check("held", 16'ha53c, cnt);
  endtask : t_load
  task automatic t_rates;
    rate(2'h1, 8'h00, 16'h0008);
    rate(2'h0, 8'h00, 16'h0002);
    rate(2'h1, 8'h01, 16'h0004);
    prescale[7:0] = 8'h00;
  endtask : t_rates
  task automatic t_gate;
    gateEnable[0] = 1'b1;
    rate(2'h1, 8'h00, 16'h0000);
    gateInputPin[0] = 1'b1;
    rate(2'h1, 8'h00, 16'h0008);
    gateEnable[0] = 1'b0;
    timerOn[0] = 1'b0;
    cyc(4);
    c0 = cnt;
    cyc(8);
    check("off", c0, cnt);
  endtask : t_gate
  // first rise after a write has no falling edge before it
  task automatic t_ext;
    clkSrcSel[1:0] = 2'h2;
    load(16'h0000);
    timerOn[0] = 1'b1;
    for (int s = 1; s >= 0; s--) begin
      extSync[0] = s[0];
      extRun = 1'b1;
      cyc(59);
      extRun = 1'b0;
      cyc(10);
      check("ext", s ? 16'h0009 : 16'h0013, cnt);
    end
  endtask : t_ext
  task automatic t_osc;
    secOscEnable = 3'h2;
    cyc(2);
    check("osc run", 16'h0001, {15'h0000, secOscRun});
    secOscEnable = 3'h1;
    cyc(4);
    c0 = cnt;
    cyc(100);
    c0 = cnt - c0;
    check("osc count", 16'h0001, {15'h0000, c0 >= 16'h0009 && c0 <= 16'h000b});
    c0[0] = secOscOutPin;
    cyc(5);
    check("osc drive", {15'h0000, !c0[0]}, {15'h0000, secOscOutPin});
    secOscEnable = 3'h0;
    cyc(2);
    check("osc stop", 16'h0000, {15'h0000, secOscRun});
    check("osc drive off", 16'h0000, {15'h0000, secOscOutPin});
  endtask : t_osc
  task automatic give_verdict;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // =====
  // main sequence and watchdog
  initial begin
    cyc(16);
    nrst = 1'b1;
    cyc(2);
    t_load();
    t_rates();
    t_gate();
    t_ext();
    t_osc();
    give_verdict();
  end
  initial begin
    #20000;
    n_fail++;
    give_verdict();
  end
endmodule : tcs_top_test
bind tcs_top tcs_top_checker #(.NT(NT), .PRE_W(PRE_W)) i_tcs_top_checker (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .clkSrcSel(clkSrcSel),
  .secOscEnable(secOscEnable),
  .timerOn(timerOn),
  .gateEnable(gateEnable),
  .gateInputPin(gateInputPin),
  .prescale(prescale),
  .writeHigh(writeHigh),
  .writeLow(writeLow),
  .writeData(writeData),
  .countHighByte(countHighByte),
  .countLowByte(countLowByte),
  .secOscRun(secOscRun)
);
`default_nettype wire
